// ### scl_pkg.sv
// package of constants and types for the strap configuration latch
package scl_pkg;

  // captured strap bundle
  typedef struct packed {
    logic integrated_magnetics_strap;
    logic [2:0] station_address_strap;
    logic [4:0] indicator_pol_strap;
    logic broadcast_address_strap;
    logic [4:0] device_mode_strap;
    logic ref_clock_out_enable_strap;
    logic indicator_style_strap;
  } scl_strap_t;

  localparam scl_strap_t SCL_STRAP_RST = '0;

  // register byte offsets
  localparam logic [7:0] SCL_OFS_STATUS = 8'h00;
  localparam logic [7:0] SCL_OFS_CONFIG = 8'h04;
  localparam logic [7:0] SCL_OFS_LIVE = 8'h0C;

  // status and live word layout
  localparam int SCL_ST_MAG_BIT = 0;
  localparam int SCL_ST_ADDR_LSB = 4;
  localparam int SCL_ST_POL_LSB = 8;
  localparam int SCL_ST_BCAST_BIT = 13;
  localparam int SCL_ST_MODE_LSB = 16;
  localparam int SCL_ST_REFCLK_BIT = 24;
  localparam int SCL_ST_STYLE_BIT = 25;
  localparam int SCL_ST_DONE_BIT = 31;

  // config word layout
  localparam int SCL_CFG_POL_LSB = 0;
  localparam int SCL_CFG_BCAST_BIT = 8;
  localparam int SCL_CFG_REFCLK_BIT = 12;
  localparam int SCL_CFG_STYLE_BIT = 16;

  // config reset values before capture
  localparam logic [4:0] SCL_POL_RST = 5'h00;
  localparam logic SCL_BCAST_RST = 1'b0;
  localparam logic SCL_REFCLK_RST = 1'b0;
  localparam logic SCL_STYLE_RST = 1'b0;

  // bus responses
  localparam logic [1:0] SCL_RESP_OKAY = 2'h0;
  localparam logic [1:0] SCL_RESP_SLVERR = 2'h2;

endpackage : scl_pkg

// ### scl_strap_board.sv
// board pull-up and pull-down resistor model that sets each strap pin
`timescale 1ns/1ps
module scl_strap_board
  import scl_pkg::*;
(
  // chosen pull per strap, 1 = pull-up, 0 = pull-down
  input wire scl_strap_t pull_sel,
  // resulting pin levels
  output scl_strap_t strap_pins
);
  // a resistor holds its level for as long as the board is powered
  assign strap_pins = pull_sel;
endmodule : scl_strap_board

// ### scl_strap_latch.sv
// strap capture, derived defaults, management address match and axi4-lite registers
`timescale 1ns/1ps
// Function
// - capture all straps when chip reset is released and derive defaults from them.
// - magnetics strap low gives normal defaults, high gives the magnetics preset.
// - three station address straps form an address 0 to 7, pulled up reads one.
// - an indicator strap captured low sets its polarity bit to one (active high).
// - an indicator strap captured high clears its polarity bit (active low).
// - broadcast strap low makes the device also answer station address 0.
// - broadcast strap high makes the device answer only its own address.
// - the broadcast enable bit loads the inverse of the broadcast strap.
// - five mode straps form a 5-bit code that selects the operating mode.
// - the reference clock output is driven after capture while its enable bit, loaded from its strap, is set.
// - style strap low selects tri-color indicators, high selects individual.
module scl_strap_latch
  import scl_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int MGMT_ADDR_W = 5
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // strap pins
  input wire scl_strap_t strap_pins,
  // management address check
  input wire logic mgmt_req,
  input wire logic [MGMT_ADDR_W-1:0] mgmt_phy_addr,
  output logic mgmt_hit,
  // derived configuration
  output logic integrated_magnetics_preset,
  output logic [2:0] station_address,
  output logic [4:0] indicator_polarity,
  output logic broadcast_address_en,
  output logic [4:0] device_mode,
  output logic ref_clock_output_pin_oe,
  output logic indicator_style,
  output logic config_valid,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // lays a strap bundle out as a register word
  function automatic logic [31:0] pack_strap(input scl_strap_t s, input logic done);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[SCL_ST_MAG_BIT] = s.integrated_magnetics_strap;
    w[SCL_ST_ADDR_LSB +: 3] = s.station_address_strap;
    w[SCL_ST_POL_LSB +: 5] = s.indicator_pol_strap;
    w[SCL_ST_BCAST_BIT] = s.broadcast_address_strap;
    w[SCL_ST_MODE_LSB +: 5] = s.device_mode_strap;
    w[SCL_ST_REFCLK_BIT] = s.ref_clock_out_enable_strap;
    w[SCL_ST_STYLE_BIT] = s.indicator_style_strap;
    w[SCL_ST_DONE_BIT] = done;
    return w;
  endfunction : pack_strap

  // word offset compare on an aligned bus address
  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    return a[ADDR_W-1:2] == ofs[ADDR_W-1:2];
  endfunction : addr_is

  scl_strap_t meta_r;
  scl_strap_t sync_r;
  scl_strap_t status_r;
  logic captured_r;
  logic [4:0] pol_r;
  logic bcast_en_r;
  logic refclk_en_r;
  logic style_r;
  logic oe_r;
  logic hit_r;
  logic awready_r;
  logic wready_r;
  logic aw_have_r;
  logic w_have_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic wr_commit;
  logic [31:0] cfg_word;
  logic [31:0] cfg_nxt;
  logic [31:0] strb_mask;
  logic own_match;

  // two-stage synchroniser, free running so it is filled during reset
  always_ff @(posedge aclk) begin
    meta_r <= strap_pins;
    sync_r <= meta_r;
  end

  // one-shot capture at the first edge after release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      captured_r <= 1'b0;
      status_r <= SCL_STRAP_RST;
    end else if (!captured_r) begin
      captured_r <= 1'b1;
      status_r <= sync_r;
    end
  end

  // current config word and byte-lane merge of a write
  always_comb begin
    cfg_word = 32'h0000_0000;
    cfg_word[SCL_CFG_POL_LSB +: 5] = pol_r;
    cfg_word[SCL_CFG_BCAST_BIT] = bcast_en_r;
    cfg_word[SCL_CFG_REFCLK_BIT] = refclk_en_r;
    cfg_word[SCL_CFG_STYLE_BIT] = style_r;
    strb_mask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    cfg_nxt = (cfg_word & ~strb_mask) | (wdata_r & strb_mask);
  end

  assign wr_commit = aw_have_r && w_have_r && !bvalid_r;

  // defaults derived from the straps, then software may retune them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pol_r <= SCL_POL_RST;
      bcast_en_r <= SCL_BCAST_RST;
      refclk_en_r <= SCL_REFCLK_RST;
      style_r <= SCL_STYLE_RST;
    end else if (!captured_r) begin
      pol_r <= ~sync_r.indicator_pol_strap;
      bcast_en_r <= ~sync_r.broadcast_address_strap;
      refclk_en_r <= sync_r.ref_clock_out_enable_strap;
      style_r <= sync_r.indicator_style_strap;
    end else if (wr_commit && addr_is(awaddr_r, SCL_OFS_CONFIG)) begin
      pol_r <= cfg_nxt[SCL_CFG_POL_LSB +: 5];
      bcast_en_r <= cfg_nxt[SCL_CFG_BCAST_BIT];
      refclk_en_r <= cfg_nxt[SCL_CFG_REFCLK_BIT];
      style_r <= cfg_nxt[SCL_CFG_STYLE_BIT];
    end
  end

  // reference clock buffer enable, off until capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= captured_r && refclk_en_r;
    end
  end

  // management address match: own address, plus 0 when enabled
  assign own_match = mgmt_phy_addr == MGMT_ADDR_W'(status_r.station_address_strap);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hit_r <= 1'b0;
    end else begin
      hit_r <= mgmt_req && captured_r &&
               (own_match || (bcast_en_r && mgmt_phy_addr == '0));
    end
  end

  // write address and data channels, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      aw_have_r <= 1'b0;
      awaddr_r <= '0;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        awready_r <= 1'b0;
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_commit) begin
        aw_have_r <= 1'b0;
      end else if (!aw_have_r && !bvalid_r) begin
        awready_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_r <= 1'b0;
      w_have_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_wvalid && wready_r) begin
        wready_r <= 1'b0;
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_commit) begin
        w_have_r <= 1'b0;
      end else if (!w_have_r && !bvalid_r) begin
        wready_r <= 1'b1;
      end
    end
  end

  // write response, unmapped offsets answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= SCL_RESP_OKAY;
    end else if (wr_commit) begin
      bvalid_r <= 1'b1;
      bresp_r <= (addr_is(awaddr_r, SCL_OFS_CONFIG) || addr_is(awaddr_r, SCL_OFS_STATUS) ||
                  addr_is(awaddr_r, SCL_OFS_LIVE)) ? SCL_RESP_OKAY : SCL_RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // read channel, answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= SCL_RESP_OKAY;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rresp_r <= SCL_RESP_OKAY;
      if (addr_is(s_axi_araddr, SCL_OFS_STATUS)) begin
        rdata_r <= pack_strap(status_r, captured_r);
      end else if (addr_is(s_axi_araddr, SCL_OFS_CONFIG)) begin
        rdata_r <= cfg_word;
      end else if (addr_is(s_axi_araddr, SCL_OFS_LIVE)) begin
        rdata_r <= pack_strap(sync_r, 1'b0);
      end else begin
        rdata_r <= 32'h0000_0000;
        rresp_r <= SCL_RESP_SLVERR;
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end else if (!rvalid_r) begin
      arready_r <= 1'b1;
    end
  end

  // outputs straight from flip-flops
  assign mgmt_hit = hit_r;
  assign integrated_magnetics_preset = status_r.integrated_magnetics_strap;
  assign station_address = status_r.station_address_strap;
  assign indicator_polarity = pol_r;
  assign broadcast_address_en = bcast_en_r;
  assign device_mode = status_r.device_mode_strap;
  assign ref_clock_output_pin_oe = oe_r;
  assign indicator_style = style_r;
  assign config_valid = captured_r;
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // checks on the captured configuration
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_capture_edge;
    !captured_r ##1 captured_r;
  endsequence

  // sampled reset in the antecedent: the edge that releases reset still resets the logic
  property p_capture;
    aresetn && !captured_r |=> captured_r && status_r == $past(sync_r);
  endproperty
  a_capture: assert property (p_capture) else $error("straps not captured");
  property p_magnetics;
    s_capture_edge |-> integrated_magnetics_preset == $past(sync_r.integrated_magnetics_strap);
  endproperty
  a_magnetics: assert property (p_magnetics) else $error("magnetics preset wrong");
  property p_station;
    s_capture_edge |-> station_address == $past(sync_r.station_address_strap);
  endproperty
  a_station: assert property (p_station) else $error("station address wrong");
  property p_pol_low;
    s_capture_edge |-> (pol_r & ~status_r.indicator_pol_strap) == ~status_r.indicator_pol_strap;
  endproperty
  a_pol_low: assert property (p_pol_low) else $error("low strap not active high");
  property p_pol_high;
    s_capture_edge |-> (pol_r & status_r.indicator_pol_strap) == 5'h00;
  endproperty
  a_pol_high: assert property (p_pol_high) else $error("high strap not active low");
  property p_bcast_hit;
    mgmt_req && captured_r && bcast_en_r && mgmt_phy_addr == '0 |=> mgmt_hit;
  endproperty
  a_bcast_hit: assert property (p_bcast_hit) else $error("address 0 not answered");
  property p_own_only;
    mgmt_req && !bcast_en_r && !own_match |=> !mgmt_hit;
  endproperty
  a_own_only: assert property (p_own_only) else $error("foreign address answered");
  property p_bcast_inv;
    s_capture_edge |-> bcast_en_r != status_r.broadcast_address_strap;
  endproperty
  a_bcast_inv: assert property (p_bcast_inv) else $error("broadcast bit not inverted");
  property p_mode;
    s_capture_edge |-> device_mode == $past(sync_r.device_mode_strap);
  endproperty
  a_mode: assert property (p_mode) else $error("mode code wrong");
  property p_refclk;
    ref_clock_output_pin_oe |-> $past(refclk_en_r) && $past(captured_r);
  endproperty
  a_refclk: assert property (p_refclk) else $error("clock out without enable");
  property p_style;
    s_capture_edge |-> indicator_style == status_r.indicator_style_strap;
  endproperty
  a_style: assert property (p_style) else $error("indicator style wrong");
  property p_hold;
    captured_r ##1 captured_r |-> $stable(status_r);
  endproperty
  a_hold: assert property (p_hold) else $error("captured straps changed");

endmodule : scl_strap_latch

// ### tb_scl_strap_latch.sv
// self-checking testbench for the strap configuration latch
`timescale 1ns/1ps
module tb_scl_strap_latch;
  import scl_pkg::*;
  logic aclk, aresetn, mgmt_req, mgmt_hit, mag, bcast_en, oe, cfg_valid, style;
  logic [4:0] mgmt_phy_addr, pol, mode;
  logic [2:0] sta;
  scl_strap_t board_cfg, strap_pins;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, rsp;
  int bad_count, checks;

  // far side and design
  scl_strap_board board (.pull_sel(board_cfg), .strap_pins(strap_pins));
  scl_strap_latch dut (.aclk(aclk), .aresetn(aresetn), .strap_pins(strap_pins),
    .mgmt_req(mgmt_req), .mgmt_phy_addr(mgmt_phy_addr), .mgmt_hit(mgmt_hit),
    .integrated_magnetics_preset(mag), .station_address(sta), .indicator_polarity(pol),
    .broadcast_address_en(bcast_en), .device_mode(mode), .ref_clock_output_pin_oe(oe),
    .indicator_style(style), .config_valid(cfg_valid), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // 10 MHz clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  // one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // expected status word for a set of strap levels
  function automatic logic [31:0] st_word(input scl_strap_t s, input logic done);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[SCL_ST_MAG_BIT] = s.integrated_magnetics_strap;
    w[SCL_ST_ADDR_LSB +: 3] = s.station_address_strap;
    w[SCL_ST_POL_LSB +: 5] = s.indicator_pol_strap;
    w[SCL_ST_BCAST_BIT] = s.broadcast_address_strap;
    w[SCL_ST_MODE_LSB +: 5] = s.device_mode_strap;
    w[SCL_ST_REFCLK_BIT] = s.ref_clock_out_enable_strap;
    w[SCL_ST_STYLE_BIT] = s.indicator_style_strap;
    w[SCL_ST_DONE_BIT] = done;
    return w;
  endfunction : st_word

  // axi4-lite write, address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  // axi4-lite read
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // management address probe, hit answered one cycle later
  task automatic probe(input logic [4:0] a, input logic exp);
    @(posedge aclk);
    mgmt_req <= 1'b1;
    mgmt_phy_addr <= a;
    @(posedge aclk);
    mgmt_req <= 1'b0;
    #1;
    chk({31'h0, mgmt_hit}, {31'h0, exp});
  endtask : probe

  // reset with given straps, check capture, then move pins and check hold
  task automatic test_capture(input scl_strap_t c);
    @(posedge aclk);
    aresetn <= 1'b0;
    board_cfg <= c;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    #1;
    chk({31'h0, cfg_valid}, 32'h1);
    chk({31'h0, mag}, {31'h0, c.integrated_magnetics_strap});
    chk({29'h0, sta}, {29'h0, c.station_address_strap});
    chk({27'h0, pol}, {27'h0, ~c.indicator_pol_strap});
    chk({31'h0, bcast_en}, {31'h0, ~c.broadcast_address_strap});
    chk({27'h0, mode}, {27'h0, c.device_mode_strap});
    chk({31'h0, oe}, {31'h0, c.ref_clock_out_enable_strap});
    chk({31'h0, style}, {31'h0, c.indicator_style_strap});
    axi_rd(SCL_OFS_STATUS, rd, rsp);
    chk(rd, st_word(c, 1'b1));
    probe({2'h0, c.station_address_strap}, 1'b1);
    probe(5'h00, ~c.broadcast_address_strap);
    probe({2'h3, c.station_address_strap}, 1'b0);
    @(posedge aclk);
    board_cfg <= ~c;
    repeat (4) @(posedge aclk);
    #1;
    chk({27'h0, mode}, {27'h0, c.device_mode_strap});
    chk({27'h0, pol}, {27'h0, ~c.indicator_pol_strap});
    axi_rd(SCL_OFS_LIVE, rd, rsp);
    chk(rd, st_word(~c, 1'b0));
    $display("capture test done");
  endtask : test_capture

  // config rewrite, read-only write, unmapped offset
  task automatic test_regs();
    axi_wr(SCL_OFS_CONFIG, 32'h0001_1115, rsp);
    chk({30'h0, rsp}, {30'h0, SCL_RESP_OKAY});
    axi_rd(SCL_OFS_CONFIG, rd, rsp);
    chk(rd, 32'h0001_1115);
    #1;
    chk({27'h0, pol}, 32'h15);
    chk({31'h0, bcast_en}, 32'h1);
    axi_wr(SCL_OFS_STATUS, 32'h0000_0000, rsp);
    chk({30'h0, rsp}, {30'h0, SCL_RESP_OKAY});
    axi_rd(SCL_OFS_STATUS, rd, rsp);
    chk(rd[SCL_ST_DONE_BIT], 1'b1);
    axi_wr(8'h08, 32'hFFFF_FFFF, rsp);
    chk({30'h0, rsp}, {30'h0, SCL_RESP_SLVERR});
    axi_rd(8'h08, rd, rsp);
    chk(rd, 32'h0);
    chk({30'h0, rsp}, {30'h0, SCL_RESP_SLVERR});
    $display("register test done");
  endtask : test_regs

  // main sequence
  initial begin
    aresetn = 1'b0;
    mgmt_req = 1'b0;
    mgmt_phy_addr = 5'h00;
    board_cfg = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    bad_count = 0;
    checks = 0;
    repeat (2) @(posedge aclk);
    test_capture('{1'b1, 3'h5, 5'h0A, 1'b0, 5'h0A, 1'b1, 1'b0});
    test_capture('{1'b0, 3'h2, 5'h15, 1'b1, 5'h11, 1'b0, 1'b1});
    test_regs();
    report_and_stop();
  end

  // watchdog against a hang
  initial begin
    #(2000 * 100);
    bad_count++;
    report_and_stop();
  end
endmodule : tb_scl_strap_latch
